// ### src/clk_switch_pkg.sv
/*
  Constants for the CPU clock source switch: register offsets on the APB
  map, field positions, writable masks, reset values and source codes.
  Assumes a 32-bit APB with byte addresses and one register per word.
*/
package clk_switch_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CLOCK_OPERATION_MODE = 8'h00;
  localparam logic [7:0] OFS_MAIN_OSC_CONTROL = 8'h04;
  localparam logic [7:0] OFS_MAIN_CLOCK_MODE = 8'h08;
  localparam logic [7:0] OFS_PROCESSOR_CLOCK_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_INTERNAL_OSC_MODE = 8'h10;
  localparam logic [7:0] OFS_OSC_STABILIZATION = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_EXT_MAIN_CLOCK_SELECT = 7;
  localparam int BIT_MAIN_OSC_ENABLE = 6;
  localparam int BIT_EXT_SUB_CLOCK_SELECT = 5;
  localparam int BIT_SUB_OSC_ENABLE = 4;
  localparam int BIT_AMP_GAIN_SELECT = 0;
  localparam int BIT_MAIN_OSC_STOP = 7;
  localparam int BIT_PERIPH_MAIN_SELECT = 2;
  localparam int BIT_CPU_MAIN_SELECT = 0;
  localparam int BIT_CPU_SUB_SELECT = 4;
  localparam int BIT_INT_OSC_STATUS = 7;
  localparam int BIT_INT_OSC_STOP = 0;

  // ************************************************************
  // Writable masks and reset values
  // ************************************************************
  localparam logic [7:0] MASK_CLOCK_OPERATION_MODE = 8'hF1;
  localparam logic [7:0] RST_CLOCK_OPERATION_MODE = 8'h00;
  localparam logic RST_MAIN_OSC_STOP = 1'b1;
  localparam logic RST_PERIPH_MAIN_SELECT = 1'b0;
  localparam logic RST_CPU_MAIN_SELECT = 1'b0;
  localparam logic RST_CPU_SUB_SELECT = 1'b0;
  localparam logic RST_INT_OSC_STOP = 1'b0;

  // ************************************************************
  // CPU clock sources, index into the source tick vector
  // ************************************************************
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_SUB = 2'h2;

  typedef enum logic [1:0] {
    CPU_RUN,
    CPU_HALT,
    CPU_STOP
  } cpu_mode_t;

endpackage

// ### src/clock_mux_glitchless.sv
/*
  Glitch-free CPU clock selector. Sources arrive as one-cycle ticks on
  mclk. A change of source waits for a tick of the old source, holds the
  output quiet, then adopts the new source on its own tick.
  Assumes every tick input is synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module clock_mux_glitchless
  import clk_switch_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Sources and request
  input wire logic [2:0] src_tick,
  input wire logic [1:0] want_src,
  input wire logic run,
  // Selected clock
  output logic cpu_tick,
  output logic [1:0] cur_src,
  output logic switching
);

  logic [1:0] target;

  // ************************************************************
  // Handover between sources
  // ************************************************************

  // Leave the old source on its edge, join the new one on its edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_src <= SRC_INT;
      target <= SRC_INT;
      switching <= 1'b0;
    end else if (ce) begin
      if (!switching) begin
        if (want_src != cur_src && src_tick[cur_src]) begin
          switching <= 1'b1;
          target <= want_src;
        end
      end else if (src_tick[target]) begin
        cur_src <= target;
        switching <= 1'b0;
      end
    end
  end

  // Output is silent while a handover is under way
  assign cpu_tick = ce & run & ~switching & src_tick[cur_src];

  // A new source is adopted only during a handover and on its own tick
  join_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$stable(cur_src) |-> $past(switching) && $past(src_tick[target]))
    else $error("source adopted off its own tick");

endmodule
`default_nettype wire

// ### src/cpu_clock_source_switch.sv
/*
  CPU clock source control: oscillator enables, gain select, internal
  oscillator status, CPU clock select bits and HALT/STOP handling, with
  its registers on an APB slave.
  Assumes sources arrive as mclk-synchronous ticks and that software
  keeps the documented order of register writes.
*/
// Our own choices: the APB interface to the registers and the address map.
// Behaviour
// - Mode register: bits 7,6,5,4 and 0
// - Main stop bit 7 halts main clock
// - Main mode: peripheral select 2, CPU select 0
// - Processor control: subsystem select in bit 4
// - Internal mode: status bit 7, stop bit 0
// - HALT entered from any clock source
// - Select bits decide the CPU clock source
// - After reset CPU runs internal oscillator
`timescale 1ns/1ns
`default_nettype none
module cpu_clock_source_switch
  import clk_switch_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock source ticks and stabilization counter
  input wire logic int_osc_tick,
  input wire logic main_crystal_tick,
  input wire logic ext_main_tick,
  input wire logic sub_crystal_tick,
  input wire logic ext_sub_tick,
  input wire logic [7:0] osc_stabilization_status,
  // CPU power requests
  input wire logic halt_req,
  input wire logic stop_req,
  input wire logic wake_req,
  // Oscillator controls
  output logic main_osc_run,
  output logic main_ext_in_en,
  output logic amp_gain,
  output logic sub_osc_run,
  output logic sub_ext_in_en,
  output logic int_osc_run,
  // CPU clock
  output logic cpu_clk_tick,
  output logic [1:0] cpu_src,
  output logic cpu_halted,
  output logic cpu_stopped
);

  logic [7:0] clock_operation_mode_reg;
  logic main_osc_stop;
  logic periph_main_select;
  logic cpu_main_select;
  logic cpu_sub_select;
  logic int_osc_stop;
  logic int_osc_status;
  cpu_mode_t mode;
  logic wr;
  logic [1:0] want_src;
  logic [2:0] src_tick;
  logic main_tick;
  logic switching;

  // ************************************************************
  // APB decode
  // ************************************************************

  // True when the offset names a register
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == OFS_CLOCK_OPERATION_MODE) || (a == OFS_MAIN_OSC_CONTROL) ||
               (a == OFS_MAIN_CLOCK_MODE) || (a == OFS_PROCESSOR_CLOCK_CONTROL) ||
               (a == OFS_INTERNAL_OSC_MODE) || (a == OFS_OSC_STABILIZATION);
  endfunction

  // Zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign wr = ce & psel & penable & pwrite;

  // Read data is captured in the setup cycle and stands in the access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (ce && psel && !penable) begin
      prdata <= 32'h00000000;
      case (paddr)
        OFS_CLOCK_OPERATION_MODE: prdata[7:0] <= clock_operation_mode_reg;
        OFS_MAIN_OSC_CONTROL: prdata[BIT_MAIN_OSC_STOP] <= main_osc_stop;
        OFS_MAIN_CLOCK_MODE: begin
          prdata[BIT_PERIPH_MAIN_SELECT] <= periph_main_select;
          prdata[BIT_CPU_MAIN_SELECT] <= cpu_main_select;
        end
        OFS_PROCESSOR_CLOCK_CONTROL: prdata[BIT_CPU_SUB_SELECT] <= cpu_sub_select;
        OFS_INTERNAL_OSC_MODE: begin
          prdata[BIT_INT_OSC_STATUS] <= int_osc_status;
          prdata[BIT_INT_OSC_STOP] <= int_osc_stop;
        end
        OFS_OSC_STABILIZATION: prdata[7:0] <= osc_stabilization_status;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************

  // Oscillator mode, gain and main stop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clock_operation_mode_reg <= RST_CLOCK_OPERATION_MODE;
      main_osc_stop <= RST_MAIN_OSC_STOP;
    end else if (wr) begin
      if (paddr == OFS_CLOCK_OPERATION_MODE) begin
        clock_operation_mode_reg <= pwdata[7:0] & MASK_CLOCK_OPERATION_MODE;
      end
      if (paddr == OFS_MAIN_OSC_CONTROL) begin
        main_osc_stop <= pwdata[BIT_MAIN_OSC_STOP];
      end
    end
  end

  // CPU and peripheral source selects, internal oscillator stop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periph_main_select <= RST_PERIPH_MAIN_SELECT;
      cpu_main_select <= RST_CPU_MAIN_SELECT;
      cpu_sub_select <= RST_CPU_SUB_SELECT;
      int_osc_stop <= RST_INT_OSC_STOP;
    end else if (wr) begin
      if (paddr == OFS_MAIN_CLOCK_MODE) begin
        periph_main_select <= pwdata[BIT_PERIPH_MAIN_SELECT];
        cpu_main_select <= pwdata[BIT_CPU_MAIN_SELECT];
      end
      if (paddr == OFS_PROCESSOR_CLOCK_CONTROL) begin
        cpu_sub_select <= pwdata[BIT_CPU_SUB_SELECT];
      end
      if (paddr == OFS_INTERNAL_OSC_MODE) begin
        int_osc_stop <= pwdata[BIT_INT_OSC_STOP];
      end
    end
  end

  // Status shows the internal oscillator running, one cycle after its enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_osc_status <= 1'b0;
    end else if (ce) begin
      int_osc_status <= int_osc_run;
    end
  end

  // ************************************************************
  // Oscillator outputs
  // ************************************************************

  // Main and internal oscillators also stop in STOP mode
  assign main_osc_run = clock_operation_mode_reg[BIT_MAIN_OSC_ENABLE] & ~main_osc_stop &
                        ~clock_operation_mode_reg[BIT_EXT_MAIN_CLOCK_SELECT] &
                        (mode != CPU_STOP);
  assign main_ext_in_en = clock_operation_mode_reg[BIT_MAIN_OSC_ENABLE] & ~main_osc_stop &
                          clock_operation_mode_reg[BIT_EXT_MAIN_CLOCK_SELECT] &
                          (mode != CPU_STOP);
  assign amp_gain = clock_operation_mode_reg[BIT_AMP_GAIN_SELECT];
  assign sub_osc_run = clock_operation_mode_reg[BIT_SUB_OSC_ENABLE] &
                       ~clock_operation_mode_reg[BIT_EXT_SUB_CLOCK_SELECT];
  assign sub_ext_in_en = clock_operation_mode_reg[BIT_SUB_OSC_ENABLE] &
                         clock_operation_mode_reg[BIT_EXT_SUB_CLOCK_SELECT];
  assign int_osc_run = ~int_osc_stop & (mode != CPU_STOP);

  // ************************************************************
  // Source selection
  // ************************************************************

  // Only enabled sources deliver ticks
  assign main_tick = (main_osc_run & main_crystal_tick) | (main_ext_in_en & ext_main_tick);
  assign src_tick = {(sub_osc_run & sub_crystal_tick) | (sub_ext_in_en & ext_sub_tick),
                     main_tick, int_osc_run & int_osc_tick};

  // Subsystem select wins, then main select, else internal
  assign want_src = cpu_sub_select ? SRC_SUB :
                    (cpu_main_select ? SRC_MAIN : SRC_INT);

  clock_mux_glitchless u_mux (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .src_tick(src_tick),
    .want_src(want_src),
    .run(mode == CPU_RUN),
    .cpu_tick(cpu_clk_tick),
    .cur_src(cpu_src),
    .switching(switching)
  );

  // ************************************************************
  // HALT and STOP
  // ************************************************************

  // STOP is refused while the CPU runs on the subsystem clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= CPU_RUN;
    end else if (ce) begin
      case (mode)
        CPU_RUN: begin
          if (stop_req && cpu_src != SRC_SUB) begin
            mode <= CPU_STOP;
          end else if (halt_req) begin
            mode <= CPU_HALT;
          end
        end
        CPU_HALT: if (wake_req) mode <= CPU_RUN;
        CPU_STOP: if (wake_req) mode <= CPU_RUN;
        default: mode <= CPU_RUN;
      endcase
    end
  end

  assign cpu_halted = (mode == CPU_HALT);
  assign cpu_stopped = (mode == CPU_STOP);

  // ************************************************************
  // Checks
  // ************************************************************

  mode_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr && paddr == OFS_CLOCK_OPERATION_MODE |=>
      clock_operation_mode_reg == ($past(pwdata[7:0]) & MASK_CLOCK_OPERATION_MODE))
    else $error("mode register write lost");

  main_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    main_osc_stop |-> !main_osc_run && !main_ext_in_en)
    else $error("main clock runs while stopped");

  main_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr && paddr == OFS_MAIN_CLOCK_MODE |=>
      cpu_main_select == $past(pwdata[0]) && periph_main_select == $past(pwdata[2]))
    else $error("main clock mode write lost");

  sub_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr && paddr == OFS_PROCESSOR_CLOCK_CONTROL |=> cpu_sub_select == $past(pwdata[4]))
    else $error("subsystem select write lost");

  int_status_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && $rose(int_osc_run) |=> int_osc_status)
    else $error("internal status did not follow enable");

  halt_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && mode == CPU_RUN && halt_req && !stop_req |=> cpu_halted)
    else $error("halt request not taken");

  stop_refused_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == CPU_RUN && cpu_src == SRC_SUB |=> !cpu_stopped)
    else $error("stop entered from subsystem clock");

  source_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !switching && $stable(want_src) && want_src != cpu_src && src_tick[cpu_src]
      |=> switching && cpu_src == $past(cpu_src))
    else $error("source change not started on old edge");

  quiet_switch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    switching |-> !cpu_clk_tick)
    else $error("cpu tick during source handover");

endmodule
`default_nettype wire

// ### tb/cpu_clock_source_switch_tb.sv
/*
  Self-checking testbench for the CPU clock source switch.
  Assumes a zero-wait APB slave and source clocks given as mclk ticks.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_clock_source_switch_tb;
  import clk_switch_pkg::*;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic pready, pslverr, rd_err;
  logic int_osc_tick = 1'b0, main_crystal_tick = 1'b0, ext_main_tick = 1'b0;
  logic sub_crystal_tick = 1'b0, ext_sub_tick = 1'b0;
  logic [7:0] osc_stabilization_status = 8'h3C;
  logic halt_req = 1'b0, stop_req = 1'b0, wake_req = 1'b0;
  logic main_osc_run, main_ext_in_en, amp_gain, sub_osc_run, sub_ext_in_en;
  logic int_osc_run, cpu_clk_tick, cpu_halted, cpu_stopped;
  logic [1:0] cpu_src;
  int n_errors = 0, comparisons = 0, cycles = 0, tcnt = 0;

  cpu_clock_source_switch u_cpu_clock_source_switch (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .int_osc_tick(int_osc_tick),
    .main_crystal_tick(main_crystal_tick), .ext_main_tick(ext_main_tick),
    .sub_crystal_tick(sub_crystal_tick), .ext_sub_tick(ext_sub_tick),
    .osc_stabilization_status(osc_stabilization_status), .halt_req(halt_req),
    .stop_req(stop_req), .wake_req(wake_req), .main_osc_run(main_osc_run),
    .main_ext_in_en(main_ext_in_en), .amp_gain(amp_gain), .sub_osc_run(sub_osc_run),
    .sub_ext_in_en(sub_ext_in_en), .int_osc_run(int_osc_run),
    .cpu_clk_tick(cpu_clk_tick), .cpu_src(cpu_src), .cpu_halted(cpu_halted),
    .cpu_stopped(cpu_stopped)
  );

  // Clock and source ticks at unlike rates
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    tcnt <= tcnt + 1;
    int_osc_tick <= (tcnt % 2 == 0);
    main_crystal_tick <= (tcnt % 3 == 0);
    ext_main_tick <= (tcnt % 4 == 1);
    sub_crystal_tick <= (tcnt % 5 == 0);
    ext_sub_tick <= (tcnt % 7 == 2);
  end

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      final_report();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until the rising edge at which pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    @(negedge mclk);
    while (pready !== 1'b1 && n < 16) begin
      @(negedge mclk);
      n++;
    end
    check(pready, 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd_data, exp);
  endtask

  // Power request as {halt, stop, wake}, held for one edge
  task automatic req(input logic [2:0] r);
    @(posedge mclk);
    {halt_req, stop_req, wake_req} <= r;
    @(posedge mclk);
    {halt_req, stop_req, wake_req} <= 3'b000;
    @(negedge mclk);
  endtask

  task automatic wait_src(input logic [1:0] s);
    int n;
    n = 0;
    while (cpu_src !== s && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check(cpu_src, s);
  endtask

  // CPU tick must follow the selected source tick
  task automatic follow(input logic [1:0] s);
    logic e;
    repeat (8) begin
      @(negedge mclk);
      e = (s == SRC_INT) ? int_osc_tick : (s == SRC_MAIN) ? main_crystal_tick : ext_sub_tick;
      check(cpu_clk_tick, e);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    check(cpu_src, SRC_INT);
    check(int_osc_run, 1'b1);
    follow(SRC_INT);
    rd(OFS_CLOCK_OPERATION_MODE, 32'h00);
    rd(OFS_MAIN_OSC_CONTROL, 32'h80);
    rd(OFS_MAIN_CLOCK_MODE, 32'h00);
    rd(OFS_PROCESSOR_CLOCK_CONTROL, 32'h00);
    rd(OFS_INTERNAL_OSC_MODE, 32'h80);
    wr(OFS_CLOCK_OPERATION_MODE, 32'hFF);
    rd(OFS_CLOCK_OPERATION_MODE, 32'hF1);
    check(main_osc_run, 1'b0);
  endtask

  task automatic t_to_main();
    wr(OFS_CLOCK_OPERATION_MODE, 32'hC1);
    wr(OFS_MAIN_OSC_CONTROL, 32'h00);
    check({main_ext_in_en, main_osc_run, amp_gain}, 3'b101);
    wr(OFS_CLOCK_OPERATION_MODE, 32'h40);
    check({main_ext_in_en, main_osc_run, amp_gain}, 3'b010);
    rd(OFS_OSC_STABILIZATION, 32'h3C);
    wr(OFS_MAIN_CLOCK_MODE, 32'h05);
    rd(OFS_MAIN_CLOCK_MODE, 32'h05);
    wait_src(SRC_MAIN);
    follow(SRC_MAIN);
  endtask

  task automatic t_to_sub();
    wr(OFS_CLOCK_OPERATION_MODE, 32'h70);
    check({sub_ext_in_en, sub_osc_run}, 2'b10);
    wr(OFS_PROCESSOR_CLOCK_CONTROL, 32'h10);
    rd(OFS_PROCESSOR_CLOCK_CONTROL, 32'h10);
    wait_src(SRC_SUB);
    follow(SRC_SUB);
    req(3'b010);
    check(cpu_stopped, 1'b0);
    req(3'b100);
    check(cpu_halted, 1'b1);
    repeat (8) begin
      @(negedge mclk);
      check(cpu_clk_tick, 1'b0);
    end
    req(3'b001);
    check(cpu_halted, 1'b0);
  endtask

  task automatic t_back();
    wr(OFS_PROCESSOR_CLOCK_CONTROL, 32'h00);
    wait_src(SRC_MAIN);
    req(3'b100);
    check(cpu_halted, 1'b1);
    req(3'b001);
    rd(OFS_INTERNAL_OSC_MODE, 32'h80);
    wr(OFS_MAIN_CLOCK_MODE, 32'h00);
    wait_src(SRC_INT);
    follow(SRC_INT);
    req(3'b010);
    check({cpu_stopped, int_osc_run, main_osc_run}, 3'b100);
    req(3'b001);
    check({cpu_stopped, int_osc_run}, 2'b01);
    wr(OFS_MAIN_OSC_CONTROL, 32'h80);
    check(main_osc_run, 1'b0);
  endtask

  task automatic t_regs();
    wr(OFS_INTERNAL_OSC_MODE, 32'h01);
    check(int_osc_run, 1'b0);
    rd(OFS_INTERNAL_OSC_MODE, 32'h01);
    wr(OFS_INTERNAL_OSC_MODE, 32'h00);
    rd(OFS_INTERNAL_OSC_MODE, 32'h80);
    wr(OFS_OSC_STABILIZATION, 32'hFF);
    check(rd_err, 1'b0);
    rd(OFS_OSC_STABILIZATION, 32'h3C);
    rd(8'h20, 32'h00);
    check(rd_err, 1'b1);
    wr(8'h24, 32'hFF);
    check(rd_err, 1'b1);
  endtask

  // Skipped steps, clock enable freeze and a reset in mid-run
  task automatic t_skip();
    wr(OFS_PROCESSOR_CLOCK_CONTROL, 32'h10);
    wait_src(SRC_SUB);
    wr(OFS_PROCESSOR_CLOCK_CONTROL, 32'h00);
    wait_src(SRC_INT);
    wr(OFS_MAIN_OSC_CONTROL, 32'h00);
    wr(OFS_MAIN_CLOCK_MODE, 32'h05);
    wait_src(SRC_MAIN);
    follow(SRC_MAIN);
    @(posedge mclk);
    ce <= 1'b0;
    repeat (4) begin
      @(negedge mclk);
      check(cpu_clk_tick, 1'b0);
    end
    @(posedge mclk);
    ce <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check(cpu_src, SRC_INT);
    rd(OFS_MAIN_CLOCK_MODE, 32'h00);
    follow(SRC_INT);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    t_reset();
    t_to_main();
    t_to_sub();
    t_back();
    t_regs();
    t_skip();
    final_report();
  end
endmodule
`default_nettype wire
